/* wss_defs.vh */
// Constants for the weld schedule sequencer
`ifndef WSS_DEFS_VH
`define WSS_DEFS_VH
// ****************************************
// Register byte offsets
// ****************************************
`define WSS_OFF_CTRL 12'h000
`define WSS_OFF_SEL 12'h004
`define WSS_OFF_EVT 12'h008
`define WSS_OFF_STAT 12'h00C
`define WSS_SCHED_BASE 12'h400
// ****************************************
// Field positions
// ****************************************
`define WSS_CTRL_SEAM 0
`define WSS_EVT_MAPPED 0
`define WSS_EVT_ENABLE 1
`define WSS_EVT_ONSTATE 2
`define WSS_EVT_INT_LSB 4
`define WSS_EVT_DLY_LSB 8
`define WSS_W2_VALVE_LSB 16
`define WSS_W2_CHAIN 24
`define WSS_W2_CCMODE 25
// ****************************************
// Reset values
// ****************************************
`define WSS_RST_CTRL 32'h0000_0000
`define WSS_RST_SEL 6'h00
`define WSS_RST_EVT 32'h0000_0000
// ****************************************
// Interval codes, also the state codes
// ****************************************
`define WSS_S_IDLE 4'h0
`define WSS_S_SQZ 4'h1
`define WSS_S_W1 4'h2
`define WSS_S_C1 4'h3
`define WSS_S_SLP 4'h4
`define WSS_S_W2 4'h5
`define WSS_S_C2 4'h6
`define WSS_S_HOLD 4'h7
`define WSS_S_OFF 4'h8
// ****************************************
// Fixed schedules of initiations b, c, d
// ****************************************
`define WSS_SCH_B 6'h14
`define WSS_SCH_C 6'h28
`define WSS_SCH_D 6'h3C
`endif

/* wss_sequencer.v */
// Weld schedule sequencer with Wishbone register access
`timescale 1ns/1ps
`include "wss_defs.vh"
module wss_sequencer #(
  parameter NSCHED = 64,
  parameter SW = 6
)(
  input wire i_clock,                  // 40 MHz system clock
  input wire i_rst_n,                  // Synchronous reset, active low
  input wire i_wb_cyc,                 // Wishbone cycle
  input wire i_wb_stb,                 // Wishbone strobe
  input wire i_wb_we,                  // Wishbone write enable
  input wire [11:0] i_wb_adr,          // Wishbone byte address
  input wire [31:0] i_wb_dat,          // Wishbone write data
  input wire [3:0] i_wb_sel,           // Wishbone byte lanes
  output reg [31:0] o_wb_dat,          // Wishbone read data
  output reg o_wb_ack,                 // Wishbone acknowledge
  input wire i_line_sync,              // AC line cycle reference pin
  input wire i_initiation_input_a,     // Initiation a, selected schedule
  input wire i_initiation_input_b,     // Initiation b
  input wire i_initiation_input_c,     // Initiation c
  input wire i_initiation_input_d,     // Initiation d, highest order
  output reg [2:0] o_valve,            // Solenoid valves 1..3
  output reg o_weld_on,                // Weld current firing
  output reg [7:0] o_heat_level,       // Heat setting for firing
  output reg o_mapped_event_output,    // General output mapped to event
  output wire o_busy                   // Sequence running
);
  // ****************************************
  // Storage and registers
  // ****************************************
  reg [31:0] mem_t0 [0:NSCHED-1];
  reg [31:0] mem_t1 [0:NSCHED-1];
  reg [31:0] mem_p [0:NSCHED-1];
  reg [31:0] ctrl_reg;
  reg [SW-1:0] sel_reg;
  reg [31:0] evt_cfg_reg;
  reg [4:0] sync1_reg;
  reg [4:0] sync2_reg;
  reg [4:0] sync3_reg;
  reg [4:0] agree_reg;
  reg line_d_reg;
  reg [3:0] state_reg;
  reg [SW-1:0] sched_reg;
  reg [7:0] cnt_reg;
  reg [7:0] elap_reg;
  reg ld_reg;
  reg [2:0] valve_reg;
  reg [7:0] lvl_reg;
  reg [8:0] err_reg;
  reg first_reg;
  reg first_cc_reg;
  reg mix_reg;
  reg ref_reg;
  reg evt_reg;
  reg arm_reg;
  reg [2:0] act_reg;
  reg weld_next;
  reg [7:0] heat_next;
  reg [31:0] rd_next;
  wire [SW-1:0] mem_idx;
  wire [31:0] t0;
  wire [31:0] t1;
  wire [31:0] p;
  wire [3:0] init_lvl;
  wire line_tick;
  wire seam;
  wire [2:0] top;
  wire held;
  wire [7:0] slp_delta;
  wire slp_up;
  wire req;
  // ****************************************
  // Helper functions
  // ****************************************
  function [31:0] bmerge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] sel;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1)
        bmerge[8*k +: 8] = sel[k] ? nw[8*k +: 8] : old[8*k +: 8];
    end
  endfunction
  // Highest-order closed initiation, 1..4, 0 when none
  function [2:0] top_init;
    input [3:0] v;
    begin
      if (v[3])
        top_init = 3'h4;
      else if (v[2])
        top_init = 3'h3;
      else if (v[1])
        top_init = 3'h2;
      else if (v[0])
        top_init = 3'h1;
      else
        top_init = 3'h0;
    end
  endfunction
  function [SW-1:0] sched_of;
    input [2:0] idx;
    input [SW-1:0] sel;
    begin
      if (idx == 3'h4)
        sched_of = `WSS_SCH_D;
      else if (idx == 3'h3)
        sched_of = `WSS_SCH_C;
      else if (idx == 3'h2)
        sched_of = `WSS_SCH_B;
      else
        sched_of = sel;
    end
  endfunction
  // ****************************************
  // Pin synchronisers and line cycle tick
  // ****************************************
  // A bit changes only when the second and third stages agree
  always @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
      sync3_reg <= 5'h00;
      agree_reg <= 5'h00;
      line_d_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= {i_line_sync, i_initiation_input_d, i_initiation_input_c,
                    i_initiation_input_b, i_initiation_input_a};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      agree_reg <= (sync2_reg & sync3_reg) | (agree_reg & (sync2_reg | sync3_reg));
      line_d_reg <= agree_reg[4];
    end
  end
  assign line_tick = agree_reg[4] & ~line_d_reg;
  assign init_lvl = agree_reg[3:0];
  assign top = top_init(init_lvl);
  assign held = (top != 3'h0);
  // weld mode bit selects seam or spot
  assign seam = ctrl_reg[`WSS_CTRL_SEAM];
  // ****************************************
  // Current schedule fields
  // ****************************************
  assign t0 = mem_t0[sched_reg];
  assign t1 = mem_t1[sched_reg];
  assign p = mem_p[sched_reg];
  assign slp_up = (p[7:0] < p[15:8]);
  assign slp_delta = slp_up ? (p[15:8] - p[7:0]) : (p[7:0] - p[15:8]);
  assign o_busy = (state_reg != `WSS_S_IDLE);
  // ****************************************
  // Sequencer
  // ****************************************
  always @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      state_reg <= `WSS_S_IDLE;
      sched_reg <= {SW{1'b0}};
      cnt_reg <= 8'h00;
      elap_reg <= 8'h00;
      ld_reg <= 1'b0;
      valve_reg <= 3'h0;
      lvl_reg <= 8'h00;
      err_reg <= 9'h000;
      first_reg <= 1'b0;
      first_cc_reg <= 1'b0;
      mix_reg <= 1'b0;
      ref_reg <= 1'b0;
      evt_reg <= 1'b0;
      arm_reg <= 1'b0;
      act_reg <= 3'h0;
    end
    else if (state_reg == `WSS_S_IDLE)
    begin
      evt_reg <= 1'b0;
      valve_reg <= 3'h0;
      if (!held)
        arm_reg <= 1'b1;
      if (arm_reg && held)
      begin
        sched_reg <= sched_of(top, sel_reg);
        act_reg <= top;
        arm_reg <= 1'b0;
        first_reg <= 1'b1;
        mix_reg <= 1'b0;
        ref_reg <= 1'b0;
        state_reg <= `WSS_S_SQZ;
        ld_reg <= 1'b1;
      end
    end
    else if (ld_reg)
    begin
      // Interval length loaded once the schedule fields are valid
      ld_reg <= 1'b0;
      elap_reg <= 8'h00;
      case (state_reg)
        `WSS_S_SQZ:
        begin
          cnt_reg <= t0[7:0];
          // first schedule energises its valves at start
          if (first_reg)
          begin
            valve_reg <= valve_reg | p[`WSS_W2_VALVE_LSB +: 3];
            first_cc_reg <= p[`WSS_W2_CCMODE];
          end
          else if (p[`WSS_W2_CCMODE] != first_cc_reg)
            mix_reg <= 1'b1;
        end
        `WSS_S_W1:
        begin
          cnt_reg <= t0[15:8];
          if (t0[15:8] != 8'h00)
            ref_reg <= 1'b1;
        end
        `WSS_S_C1:
          cnt_reg <= t0[23:16];
        `WSS_S_SLP:
        begin
          // no slope without a reference heat in mixed chains
          cnt_reg <= (mix_reg && !ref_reg) ? 8'h00 : t0[31:24];
          lvl_reg <= p[7:0];
          err_reg <= 9'h000;
        end
        `WSS_S_W2:
        begin
          cnt_reg <= t1[7:0];
          if (t1[7:0] != 8'h00)
            ref_reg <= 1'b1;
        end
        `WSS_S_C2:
          cnt_reg <= t1[15:8];
        `WSS_S_HOLD:
          cnt_reg <= t1[23:16];
        default:
          cnt_reg <= t1[31:24];
      endcase
    end
    else
    begin
      if (line_tick && elap_reg != 8'hFF)
        elap_reg <= elap_reg + 8'h01;
      // event on after its delay inside the chosen interval
      if (evt_cfg_reg[`WSS_EVT_ENABLE] && state_reg == evt_cfg_reg[`WSS_EVT_INT_LSB +: 4] &&
          elap_reg >= evt_cfg_reg[`WSS_EVT_DLY_LSB +: 8])
        evt_reg <= 1'b1;
      // ramp heat level by steps of one toward second heat
      if (state_reg == `WSS_S_SLP)
      begin
        if (line_tick)
          err_reg <= err_reg + {1'b0, slp_delta};
        else if (err_reg >= {1'b0, t0[31:24]} && t0[31:24] != 8'h00)
        begin
          err_reg <= err_reg - {1'b0, t0[31:24]};
          lvl_reg <= slp_up ? lvl_reg + 8'h01 : lvl_reg - 8'h01;
        end
      end
      if (seam && state_reg >= `WSS_S_W1 && state_reg <= `WSS_S_C2 && !held)
      begin
        // opening the contact ends the current
        state_reg <= `WSS_S_HOLD;
        ld_reg <= 1'b1;
      end
      else if (seam && state_reg >= `WSS_S_W1 && state_reg <= `WSS_S_C2 && top != act_reg)
      begin
        // takeover keeps the interval, so current has no gap
        act_reg <= top;
        sched_reg <= sched_of(top, sel_reg);
      end
      else if (cnt_reg != 8'h00)
      begin
        // zero second cool means continuous seam current
        if (line_tick && !(seam && state_reg == `WSS_S_W2 && t1[15:8] == 8'h00))
          cnt_reg <= cnt_reg - 8'h01;
      end
      else
      begin
        // fixed interval order, zero counts pass in two clocks, load then step
        ld_reg <= 1'b1;
        case (state_reg)
          `WSS_S_SQZ:
          begin
            // later schedule valves wait for the squeeze
            // or switch on at once when squeeze is zero
            // clamp schedule passes straight on after squeeze
            valve_reg <= valve_reg | p[`WSS_W2_VALVE_LSB +: 3];
            state_reg <= `WSS_S_W1;
          end
          `WSS_S_W1:
            state_reg <= `WSS_S_C1;
          `WSS_S_C1:
            state_reg <= `WSS_S_SLP;
          `WSS_S_SLP:
            state_reg <= `WSS_S_W2;
          `WSS_S_W2:
            state_reg <= `WSS_S_C2;
          `WSS_S_C2:
            // only second heat and cool repeat in seam
            state_reg <= (seam && held) ? `WSS_S_W2 : `WSS_S_HOLD;
          `WSS_S_HOLD:
          begin
            if (!seam && p[`WSS_W2_CHAIN])
            begin
              // valves carry over into the chained schedule
              sched_reg <= sched_reg + {{(SW-1){1'b0}}, 1'b1};
              first_reg <= 1'b0;
              state_reg <= `WSS_S_SQZ;
            end
            else
            begin
              // all valves drop together at the final hold end
              valve_reg <= 3'h0;
              state_reg <= `WSS_S_OFF;
            end
          end
          default:
          begin
            ld_reg <= 1'b0;
            state_reg <= `WSS_S_IDLE;
          end
        endcase
      end
    end
  end
  // ****************************************
  // Outputs
  // ****************************************
  always @*
  begin
    heat_next = 8'h00;
    weld_next = o_weld_on;
    // transit clocks with zero counts keep current unchanged
    // A final zero hold must not carry current into idle
    if (state_reg == `WSS_S_IDLE || state_reg == `WSS_S_OFF)
      weld_next = 1'b0;
    else if (!ld_reg && cnt_reg != 8'h00)
      weld_next = (state_reg == `WSS_S_W1 || state_reg == `WSS_S_SLP || state_reg == `WSS_S_W2);
    // heat follows the schedule now running
    // Transit clocks keep the heat already firing, never a zero interval's level
    if (ld_reg || cnt_reg == 8'h00)
      heat_next = o_heat_level;
    else if (state_reg == `WSS_S_W1)
      heat_next = p[7:0];
    else if (state_reg == `WSS_S_SLP)
      heat_next = lvl_reg;
    else if (state_reg == `WSS_S_W2)
      heat_next = p[15:8];
  end
  always @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      o_weld_on <= 1'b0;
      o_heat_level <= 8'h00;
      o_valve <= 3'h0;
      o_mapped_event_output <= 1'b0;
    end
    else
    begin
      o_weld_on <= weld_next;
      o_heat_level <= weld_next ? heat_next : 8'h00;
      o_valve <= valve_reg;
      if (evt_cfg_reg[`WSS_EVT_MAPPED])
        o_mapped_event_output <= evt_reg ~^ evt_cfg_reg[`WSS_EVT_ONSTATE];
      else
        o_mapped_event_output <= 1'b0;
    end
  end
  // ****************************************
  // Wishbone slave, one wait state
  // ****************************************
  assign req = i_wb_cyc & i_wb_stb;
  assign mem_idx = i_wb_adr[SW+3:4];
  always @*
  begin
    rd_next = 32'h0000_0000;
    if (i_wb_adr == `WSS_OFF_CTRL)
      rd_next = ctrl_reg;
    else if (i_wb_adr == `WSS_OFF_SEL)
      rd_next = {{(32-SW){1'b0}}, sel_reg};
    else if (i_wb_adr == `WSS_OFF_EVT)
      rd_next = evt_cfg_reg;
    else if (i_wb_adr == `WSS_OFF_STAT)
      rd_next = {{(16-SW){1'b0}}, sched_reg, 6'h00, evt_reg, o_weld_on, 1'b0, valve_reg, state_reg};
    else if (i_wb_adr >= `WSS_SCHED_BASE && i_wb_adr[3:2] == 2'h0)
      rd_next = mem_t0[mem_idx];
    else if (i_wb_adr >= `WSS_SCHED_BASE && i_wb_adr[3:2] == 2'h1)
      rd_next = mem_t1[mem_idx];
    else if (i_wb_adr >= `WSS_SCHED_BASE && i_wb_adr[3:2] == 2'h2)
      rd_next = mem_p[mem_idx];
  end
  // Writes land on the edge where the master sees ack
  always @(posedge i_clock)
  begin
    if (req && i_wb_we && o_wb_ack && i_wb_adr >= `WSS_SCHED_BASE)
    begin
      if (i_wb_adr[3:2] == 2'h0)
        mem_t0[mem_idx] <= bmerge(mem_t0[mem_idx], i_wb_dat, i_wb_sel);
      else if (i_wb_adr[3:2] == 2'h1)
        mem_t1[mem_idx] <= bmerge(mem_t1[mem_idx], i_wb_dat, i_wb_sel);
      else if (i_wb_adr[3:2] == 2'h2)
        mem_p[mem_idx] <= bmerge(mem_p[mem_idx], i_wb_dat, i_wb_sel);
    end
  end
  always @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
      ctrl_reg <= `WSS_RST_CTRL;
      sel_reg <= `WSS_RST_SEL;
      evt_cfg_reg <= `WSS_RST_EVT;
    end
    else
    begin
      o_wb_ack <= req & ~o_wb_ack;
      if (req && !o_wb_ack)
        o_wb_dat <= rd_next;
      if (req && i_wb_we && o_wb_ack)
      begin
        if (i_wb_adr == `WSS_OFF_CTRL)
          ctrl_reg <= bmerge(ctrl_reg, i_wb_dat, i_wb_sel) & 32'h0000_0001;
        else if (i_wb_adr == `WSS_OFF_SEL && i_wb_sel[0])
          sel_reg <= i_wb_dat[SW-1:0];
        else if (i_wb_adr == `WSS_OFF_EVT)
          evt_cfg_reg <= bmerge(evt_cfg_reg, i_wb_dat, i_wb_sel) & 32'h0000_FFF7;
      end
    end
  end
endmodule

/* wss_monitor.sv */
// Port checker for the weld schedule sequencer
`timescale 1ns/1ps
module wss_monitor (
  input wire i_clock,          // clock
  input wire i_rst_n,          // reset
  input wire i_wb_cyc,         // cycle
  input wire i_wb_stb,         // strobe
  input wire o_wb_ack,         // ack
  input wire [2:0] o_valve,    // valves
  input wire o_weld_on,        // firing
  input wire [7:0] o_heat_level, // heat
  input wire o_busy            // running
);
  // ****************************************
  // Bus and sequence checks
  // ****************************************
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);
  ack_pulse_a:
    assert property (o_wb_ack |=> !o_wb_ack) else $error("ack held two cycles");
  ack_time_a:
    assert property ($rose(i_wb_cyc && i_wb_stb) |=> o_wb_ack) else $error("ack not one cycle after request");
  ack_cause_a:
    assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb)) else $error("ack without request");
  heat_off_a:
    assert property (!o_weld_on |-> o_heat_level == 8'h00) else $error("heat shown while weld off");
  weld_busy_a:
    assert property (o_weld_on |-> o_busy) else $error("weld on outside a sequence");
  idle_valve_a:
    assert property (!o_busy |-> o_valve == 3'h0) else $error("valve on while idle");
  valve_keep_a:
    assert property (o_busy && $past(o_busy) |-> o_valve == 3'h0 || (o_valve & $past(o_valve)) == $past(o_valve))
      else $error("valve dropped mid chain");
  end_quiet_a:
    assert property ($fell(o_busy) |-> $past(o_valve) == 3'h0 && !$past(o_weld_on)) else $error("sequence ended live");
endmodule
bind wss_sequencer wss_monitor wss_monitor_inst (.i_clock, .i_rst_n, .i_wb_cyc, .i_wb_stb, .o_wb_ack, .o_valve,
  .o_weld_on, .o_heat_level, .o_busy);

/* wss_machine_model.sv */
// Machine side: initiation contacts and line reference
`timescale 1ns/1ps
module wss_machine_model #(
  parameter HALF = 16
)(
  input wire i_clock,          // clock
  input wire [3:0] i_press,    // contacts wanted closed
  output reg [3:0] o_contact,  // contacts a..d
  output reg o_line_sync       // line reference
);
  integer cnt = 0;
  initial o_contact = 4'h0;
  initial o_line_sync = 1'b0;
  // Free running, as the mains never stops
  always @(posedge i_clock)
  begin
    o_contact <= i_press;
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1)
      o_line_sync <= ~o_line_sync;
  end
endmodule

/* wss_sequencer_tb_top.sv */
// Testbench for the weld schedule sequencer
`timescale 1ns/1ps
`include "wss_defs.vh"
module wss_sequencer_tb_top;
  localparam P = 32;
  typedef struct packed {logic [3:0] sw; logic [5:0] s; logic [31:0] w0, w1, w2; logic [7:0] tk, ht; logic [2:0] vl;}
    wss_row_t;
  wss_row_t rows [0:3];
  reg i_clock = 1'b0;
  reg i_rst_n = 1'b0;
  reg i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0, pw = 1'b0, ev, ev0;
  reg [11:0] i_wb_adr = 12'h000;
  reg [31:0] i_wb_dat = 32'h0, rd;
  reg [3:0] i_wb_sel = 4'h0, press = 4'h0;
  reg [7:0] heat;
  reg [2:0] vs;
  wire [31:0] o_wb_dat;
  wire [3:0] ct;
  wire [2:0] o_valve;
  wire [7:0] o_heat_level;
  wire o_wb_ack, ls, o_weld_on, o_mapped_event_output, o_busy;
  integer err_count = 0, checks_done = 0, n, i, wclk, falls, rises, h22, mid;
  always #12.5 i_clock = ~i_clock;
  wss_machine_model wss_machine_model_inst (.i_clock, .i_press(press), .o_contact(ct), .o_line_sync(ls));
  wss_sequencer wss_sequencer_inst (.i_clock, .i_rst_n, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_dat,
    .i_wb_sel, .o_wb_dat, .o_wb_ack, .i_line_sync(ls), .i_initiation_input_a(ct[0]), .i_initiation_input_b(ct[1]),
    .i_initiation_input_c(ct[2]), .i_initiation_input_d(ct[3]), .o_valve, .o_weld_on, .o_heat_level,
    .o_mapped_event_output, .o_busy);
  // ****************************************
  // Observation while a sequence runs
  // ****************************************
  always @(posedge i_clock)
  begin
    pw <= o_weld_on;
    if (o_busy === 1'b1)
    begin
      vs <= vs | o_valve;
      ev <= ev | o_mapped_event_output;
      if (o_weld_on === 1'b1 && wclk == 0)
        ev0 <= o_mapped_event_output;
      if (o_weld_on === 1'b1)
      begin
        wclk <= wclk + 1;
        heat <= o_heat_level;
        if (o_heat_level === 8'h22)
          h22 <= h22 + 1;
        if (o_heat_level > 8'h10 && o_heat_level < 8'h30)
          mid <= mid + 1;
      end
      if (o_weld_on === 1'b1 && pw === 1'b0)
        rises <= rises + 1;
      if (o_weld_on === 1'b0 && pw === 1'b1)
        falls <= falls + 1;
    end
  end
  // ****************************************
  // Tasks
  // ****************************************
  task test_done;
  begin
    if (err_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
  begin
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
      err_count = err_count + 1;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  end
  endtask
  task wb(input w, input [11:0] a, input [31:0] d);
  begin
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= w;
    i_wb_adr <= a;
    i_wb_dat <= d;
    i_wb_sel <= 4'hF;
    n = 0;
    do
    begin
      @(posedge i_clock);
      n = n + 1;
    end
    while (o_wb_ack !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      chk(0, 1);
      test_done;
    end
    rd = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    @(posedge i_clock);
  end
  endtask
  task sch(input [5:0] s, input [31:0] w0, input [31:0] w1, input [31:0] w2);
  begin
    wb(1'b1, `WSS_SCHED_BASE + {s, 4'h0}, w0);
    wb(1'b1, `WSS_SCHED_BASE + {s, 4'h4}, w1);
    wb(1'b1, `WSS_SCHED_BASE + {s, 4'h8}, w2);
  end
  endtask
  task wt(input v);
  begin
    n = 0;
    while (o_busy !== v && n < 5000)
    begin
      @(posedge i_clock);
      n = n + 1;
    end
    if (n >= 5000)
    begin
      chk(0, 1);
      test_done;
    end
  end
  endtask
  task st(input [3:0] m);
  begin
    {wclk, falls, rises, h22, mid} = 0;
    {vs, ev, ev0, heat} = 0;
    press <= m;
    wt(1'b1);
  end
  endtask
  task run(input [3:0] m, input integer k);
  begin
    st(m);
    repeat (k * P) @(posedge i_clock);
    press <= 4'h0;
    wt(1'b0);
  end
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    rows[0] = '{4'h1, 6'h05, 32'h2, 32'h0001_0003, 32'h0001_4000, 8'h3, 8'h40, 3'h1};
    rows[1] = '{4'h2, `WSS_SCH_B, 32'h0201, 32'h0001_0000, 32'h0002_0030, 8'h2, 8'h30, 3'h2};
    rows[2] = '{4'h4, `WSS_SCH_C, 32'h1, 32'h0001_0001, 32'h0004_5500, 8'h1, 8'h55, 3'h4};
    rows[3] = '{4'h8, `WSS_SCH_D, 32'h1, 32'h0001_0002, 32'h0003_6600, 8'h2, 8'h66, 3'h3};
    repeat (12) @(posedge i_clock);
    i_rst_n <= 1'b1;
    wb(1'b1, `WSS_OFF_SEL, 32'h5);
    for (i = 0; i < 4; i = i + 1)
    begin
      sch(rows[i].s, rows[i].w0, rows[i].w1, rows[i].w2);
      run(rows[i].sw, 1);
      chk((wclk + P / 2) / P, rows[i].tk);
      chk(heat, rows[i].ht);
      chk(vs, rows[i].vl);
    end
    // Clamp step, then two chained schedules firing through
    sch(6'h09, 32'h2, 32'h0, 32'h0101_0000);
    sch(6'h0A, 32'h2, 32'h0000_0002, 32'h0101_6000);
    sch(6'h0B, 32'h0, 32'h0001_0002, 32'h0003_7000);
    wb(1'b1, `WSS_OFF_SEL, 32'h9);
    run(4'h1, 1);
    chk((wclk + P / 2) / P, 4);
    chk(falls, 1);
    chk(vs, 3'h3);
    chk(heat, 8'h70);
    // Event needs mapping before it follows its setting
    wb(1'b1, `WSS_OFF_SEL, 32'h5);
    wb(1'b1, `WSS_OFF_EVT, 32'h0000_0156);
    run(4'h1, 1);
    chk(ev, 1'b0);
    wb(1'b1, `WSS_OFF_EVT, 32'h0000_0157);
    run(4'h1, 1);
    chk(ev, 1'b1);
    chk(ev0, 1'b0);
    // Seam: priority and takeover without a gap
    wb(1'b1, `WSS_OFF_CTRL, 32'h1);
    sch(`WSS_SCH_B, 32'h1, 32'h0001_0001, 32'h0001_4400);
    sch(`WSS_SCH_C, 32'h1, 32'h0001_0001, 32'h0001_6600);
    st(4'h6);
    repeat (8 * P) @(posedge i_clock);
    chk(o_weld_on, 1'b1);
    chk(o_heat_level, 8'h66);
    press <= 4'h2;
    repeat (4 * P) @(posedge i_clock);
    chk(o_heat_level, 8'h44);
    press <= 4'h0;
    wt(1'b0);
    chk(falls, 1);
    sch(`WSS_SCH_D, 32'h0001_0201, 32'h0001_0101, 32'h0001_3322);
    run(4'h8, 12);
    chk(rises >= 4, 1);
    chk((h22 + P / 2) / P, 2);
    // Back in spot a held contact does not stretch the weld
    wb(1'b1, `WSS_OFF_CTRL, 32'h0);
    run(4'h1, 10);
    chk((wclk + P / 2) / P, 3);
    // Upslope inside one schedule, then a mixed chain with no heat before its slope
    sch(6'h07, 32'h0400_0101, 32'h0001_0001, 32'h0001_3010);
    wb(1'b1, `WSS_OFF_SEL, 32'h7);
    run(4'h1, 1);
    chk(mid > 0, 1);
    chk(heat, 8'h30);
    chk((wclk + P / 2) / P, 6);
    sch(6'h0C, 32'h1, 32'h0, 32'h0101_0000);
    sch(6'h0D, 32'h0200_0000, 32'h0001_0002, 32'h0201_3010);
    wb(1'b1, `WSS_OFF_SEL, 32'hC);
    run(4'h1, 1);
    chk((wclk + P / 2) / P, 1);
    // Reset in mid sequence, then register defaults
    st(4'h1);
    repeat (3 * P) @(posedge i_clock);
    i_rst_n <= 1'b0;
    press <= 4'h0;
    repeat (12) @(posedge i_clock);
    chk({o_valve, o_weld_on, o_busy}, 5'h00);
    i_rst_n <= 1'b1;
    @(posedge i_clock);
    wb(1'b0, `WSS_OFF_CTRL, 32'h0);
    chk(rd, `WSS_RST_CTRL);
    wb(1'b0, `WSS_OFF_SEL, 32'h0);
    chk(rd, `WSS_RST_SEL);
    wb(1'b0, `WSS_OFF_EVT, 32'h0);
    chk(rd, `WSS_RST_EVT);
    wb(1'b1, 12'h010, 32'hFFFF_FFFF);
    wb(1'b0, 12'h010, 32'h0);
    chk(rd, 32'h0);
    test_done;
  end
endmodule
